// *** src/amvg_regs.sv ***
`timescale 1ns/10ps
// ****************************************************************
// Volume, gain and fault register slice
// ****************************************************************
module amvg_regs (
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // Register control port
    input  wire amvg_pkg::amvg_reg_req_s reg_req_i,
    output logic [7:0]                  reg_rdata_o,
    output logic                        reg_rvalid_o,
    // Controls held in other registers
    input  wire logic                   vol_lsb_i,
    input  wire logic                   mute_i,
    input  wire logic                   ramp_rate_sel_i,
    input  wire logic                   speed_mode_sel_i,
    input  wire logic                   frame_tick_i,
    // Fault detectors
    input  wire amvg_pkg::amvg_fault_s  fault_i,
    // Volume outputs
    output logic [8:0]                  digital_volume_o,
    output logic [9:0]                  volume_qdb_o,
    output logic                        vol_muted_o,
    output logic                        vol_ramping_o,
    // Amplifier settings
    output logic [4:0]                  pwm_ratio_o,
    output logic [1:0]                  analog_gain_o,
    output logic [11:0]                 analog_gain_cdbv_o,
    output logic [1:0]                  overcurrent_threshold_o,
    output logic [6:0]                  oc_percent_o,
    // Fault flags
    output logic                        clock_error_flag_o,
    output logic                        overcurrent_flag_o,
    output logic                        dc_detect_flag_o,
    output logic                        overtemp_flag_o
);
    import amvg_pkg::*;

    // ************************************************************
    // Register storage
    // ************************************************************
    logic [7:0] volume_upper_q,   volume_upper_d;
    logic [7:0] analog_control_q, analog_control_d;
    logic [AMVG_FCFG_MSB:AMVG_OCTH_LSB] fault_cfg_q, fault_cfg_d;

    logic wr_volume;
    logic wr_analog;
    logic wr_fault;
    logic rd_fault;

    // Address decode for writes and for the fault register read
    always_comb begin
        wr_volume = 1'b0;
        wr_analog = 1'b0;
        wr_fault  = 1'b0;
        rd_fault  = 1'b0;
        if (reg_req_i.addr == AMVG_OFS_VOLUME) begin
            wr_volume = reg_req_i.wr;
        end else if (reg_req_i.addr == AMVG_OFS_ANALOG) begin
            wr_analog = reg_req_i.wr;
        end else if (reg_req_i.addr == AMVG_OFS_FAULT) begin
            wr_fault  = reg_req_i.wr;
            rd_fault  = reg_req_i.rd;
        end
    end

    // Write data lands on the edge that sees the strobe
    always_comb begin
        volume_upper_d   = volume_upper_q;
        analog_control_d = analog_control_q;
        fault_cfg_d      = fault_cfg_q;
        if (wr_volume) begin
            volume_upper_d = reg_req_i.wdata;
        end
        // Reserved bits are stored as written; the host keeps them at 0 and 01
        if (wr_analog) begin
            analog_control_d = reg_req_i.wdata;
        end
        if (wr_fault) begin
            fault_cfg_d = reg_req_i.wdata[AMVG_FCFG_MSB:AMVG_OCTH_LSB];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            volume_upper_q   <= AMVG_RST_VOLUME;
            analog_control_q <= AMVG_RST_ANALOG;
            fault_cfg_q      <= AMVG_RST_FAULT_CFG[AMVG_FCFG_MSB:AMVG_OCTH_LSB];
        end else begin
            volume_upper_q   <= volume_upper_d;
            analog_control_q <= analog_control_d;
            fault_cfg_q      <= fault_cfg_d;
        end
    end

    // ************************************************************
    // Fault flags
    // ************************************************************
    logic clock_error_flag_q, clock_error_flag_d;
    logic oce_q,  oce_d;
    logic dce_q,  dce_d;
    logic ote_q,  ote_d;

    // Latched flags clear on a read of the fault register; a detector
    // event in the same cycle as that read wins so nothing is lost
    always_comb begin
        clock_error_flag_d = fault_i.clk_err;
        oce_d  = fault_i.overcurrent | (oce_q & ~rd_fault);
        dce_d  = fault_i.dc_detect   | (dce_q & ~rd_fault);
        ote_d  = fault_i.overtemp    | (ote_q & ~rd_fault);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            clock_error_flag_q <= 1'b0;
            oce_q  <= 1'b0;
            dce_q  <= 1'b0;
            ote_q  <= 1'b0;
        end else begin
            clock_error_flag_q <= clock_error_flag_d;
            oce_q  <= oce_d;
            dce_q  <= dce_d;
            ote_q  <= ote_d;
        end
    end

    // ************************************************************
    // Read port
    // ************************************************************
    logic [7:0] rdata_q,  rdata_d;
    logic       rvalid_q, rvalid_d;

    // Read data is registered, so it appears one cycle after the strobe;
    // the fault byte shows the flags as held before that cycle's event
    always_comb begin
        rdata_d  = AMVG_RDATA_NONE;
        rvalid_d = reg_req_i.rd;
        if (reg_req_i.rd) begin
            if (reg_req_i.addr == AMVG_OFS_VOLUME) begin
                rdata_d = volume_upper_q;
            end else if (reg_req_i.addr == AMVG_OFS_ANALOG) begin
                rdata_d = analog_control_q;
            end else if (reg_req_i.addr == AMVG_OFS_FAULT) begin
                rdata_d[AMVG_FCFG_MSB:AMVG_OCTH_LSB] = fault_cfg_q;
                rdata_d[AMVG_CLOCK_ERROR_FLAG_BIT] = clock_error_flag_q;
                rdata_d[AMVG_OCE_BIT]  = oce_q;
                rdata_d[AMVG_DCE_BIT]  = dce_q;
                rdata_d[AMVG_OTE_BIT]  = ote_q;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q  <= AMVG_RDATA_NONE;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // ************************************************************
    // Volume path
    // ************************************************************
    logic [AMVG_VOL_W-1:0] vol_code;
    logic                  vol_mute;
    logic [AMVG_VOL_W-1:0] vol_target;
    logic [AMVG_VOL_W-1:0] ramp_code;
    logic                  ramp_moving;

    // Full code joins the stored upper bits with the external LSB
    always_comb begin
        vol_code   = {volume_upper_q, vol_lsb_i};
        vol_mute   = mute_i || (vol_code < AMVG_VOL_MUTE_LIM);
        vol_target = vol_mute ? AMVG_VOL_FLOOR : vol_code;
    end

    // Every target change ramps, so volume never jumps audibly
    amvg_vol_ramp u_ramp (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .frame_tick_i (frame_tick_i),
        .ramp_fast_i  (ramp_rate_sel_i),
        .target_i     (vol_target),
        .code_o       (ramp_code),
        .moving_o     (ramp_moving)
    );

    // ************************************************************
    // Registered outputs
    // ************************************************************
    logic [8:0]  dvol_q,  dvol_d;
    logic [9:0]  qdb_q,   qdb_d;
    logic        muted_q, muted_d;
    logic        ramp_q,  ramp_d;
    logic [4:0]  pwm_q,   pwm_d;
    logic [1:0]  gain_q,  gain_d;
    logic [11:0] cdbv_q,  cdbv_d;
    logic [1:0]  octh_q,  octh_d;
    logic [6:0]  ocpc_q,  ocpc_d;

    // Gain is signed quarter dB relative to the zero dB code
    always_comb begin
        dvol_d  = ramp_code;
        qdb_d   = 10'({1'b0, ramp_code} - {1'b0, AMVG_VOL_ZERO_DB});
        muted_d = vol_mute && (ramp_code == AMVG_VOL_FLOOR);
        ramp_d  = ramp_moving;
        pwm_d   = amvg_pwm_ratio(analog_control_q[AMVG_PWM_MSB:AMVG_PWM_LSB],
                                 speed_mode_sel_i);
        gain_d  = analog_control_q[AMVG_GAIN_MSB:AMVG_GAIN_LSB];
        cdbv_d  = amvg_gain_cdbv(gain_d);
        octh_d  = fault_cfg_q[AMVG_OCTH_MSB:AMVG_OCTH_LSB];
        ocpc_d  = amvg_oc_percent(octh_d);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dvol_q  <= AMVG_VOL_ZERO_DB;
            qdb_q   <= 10'h000;
            muted_q <= 1'b0;
            ramp_q  <= 1'b0;
            pwm_q   <= amvg_pwm_ratio(AMVG_RST_ANALOG[AMVG_PWM_MSB:AMVG_PWM_LSB], 1'b0);
            gain_q  <= AMVG_RST_ANALOG[AMVG_GAIN_MSB:AMVG_GAIN_LSB];
            cdbv_q  <= amvg_gain_cdbv(AMVG_RST_ANALOG[AMVG_GAIN_MSB:AMVG_GAIN_LSB]);
            octh_q  <= AMVG_RST_FAULT_CFG[AMVG_OCTH_MSB:AMVG_OCTH_LSB];
            ocpc_q  <= amvg_oc_percent(AMVG_RST_FAULT_CFG[AMVG_OCTH_MSB:AMVG_OCTH_LSB]);
        end else begin
            dvol_q  <= dvol_d;
            qdb_q   <= qdb_d;
            muted_q <= muted_d;
            ramp_q  <= ramp_d;
            pwm_q   <= pwm_d;
            gain_q  <= gain_d;
            cdbv_q  <= cdbv_d;
            octh_q  <= octh_d;
            ocpc_q  <= ocpc_d;
        end
    end

    // Port assignments straight from flops
    assign reg_rdata_o             = rdata_q;
    assign reg_rvalid_o            = rvalid_q;
    assign digital_volume_o        = dvol_q;
    assign volume_qdb_o            = qdb_q;
    assign vol_muted_o             = muted_q;
    assign vol_ramping_o           = ramp_q;
    assign pwm_ratio_o             = pwm_q;
    assign analog_gain_o           = gain_q;
    assign analog_gain_cdbv_o      = cdbv_q;
    assign overcurrent_threshold_o = octh_q;
    assign oc_percent_o            = ocpc_q;
    assign clock_error_flag_o      = clock_error_flag_q;
    assign overcurrent_flag_o      = oce_q;
    assign dc_detect_flag_o        = dce_q;
    assign overtemp_flag_o         = ote_q;

endmodule : amvg_regs

// *** common/amvg_pkg.sv ***
// ****************************************************************
// Shared constants and types
// ****************************************************************
package amvg_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] AMVG_OFS_VOLUME    = 8'h04;
    localparam logic [7:0] AMVG_OFS_ANALOG    = 8'h06;
    localparam logic [7:0] AMVG_OFS_FAULT     = 8'h08;

    localparam logic [7:0] AMVG_RST_VOLUME    = 8'hcf;
    localparam logic [7:0] AMVG_RST_ANALOG    = 8'h55;
    localparam logic [7:0] AMVG_RST_FAULT_CFG = 8'h00;
    localparam logic [7:0] AMVG_RDATA_NONE    = 8'h00;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int AMVG_PWM_LSB     = 4;
    localparam int AMVG_PWM_MSB     = 6;
    localparam int AMVG_GAIN_LSB    = 2;
    localparam int AMVG_GAIN_MSB    = 3;
    localparam int AMVG_OCTH_LSB    = 4;
    localparam int AMVG_OCTH_MSB    = 5;
    localparam int AMVG_FCFG_MSB    = 7;
    localparam int AMVG_CLOCK_ERROR_FLAG_BIT    = 3;
    localparam int AMVG_OCE_BIT     = 2;
    localparam int AMVG_DCE_BIT     = 1;
    localparam int AMVG_OTE_BIT     = 0;

    // ************************************************************
    // Volume code and ramp
    // ************************************************************
    localparam int          AMVG_VOL_W        = 9;
    localparam logic [8:0]  AMVG_VOL_MUTE_LIM = 9'h008;
    localparam logic [8:0]  AMVG_VOL_ZERO_DB  = 9'h19e;
    localparam logic [8:0]  AMVG_VOL_FLOOR    = 9'h000;
    localparam int          AMVG_RAMP_SLOW    = 8;
    localparam logic [2:0]  AMVG_RAMP_CNT_MAX = 3'(AMVG_RAMP_SLOW - 1);

    // ************************************************************
    // Bundles
    // ************************************************************
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } amvg_reg_req_s;

    typedef struct packed {
        logic clk_err;
        logic overcurrent;
        logic dc_detect;
        logic overtemp;
    } amvg_fault_s;

    typedef enum logic {
        AMVG_RAMP_IDLE,
        AMVG_RAMP_MOVE
    } amvg_ramp_e;

    // ************************************************************
    // Decode tables
    // ************************************************************
    // Switching ratio to frame clock, single speed; double speed halves it
    function automatic logic [4:0] amvg_pwm_ratio(input logic [2:0] code,
                                                  input logic       dbl);
        logic [4:0] r;
        r = 5'h00;
        case (code)
            3'h0: r = 5'h06;
            3'h1: r = 5'h08;
            3'h2: r = 5'h0a;
            3'h3: r = 5'h0c;
            3'h4: r = 5'h0e;
            3'h5: r = 5'h10;
            3'h6: r = 5'h14;
            default: r = 5'h18;
        endcase
        return dbl ? (r >> 1) : r;
    endfunction : amvg_pwm_ratio

    // Output level in hundredths of a dBV
    function automatic logic [11:0] amvg_gain_cdbv(input logic [1:0] code);
        case (code)
            2'h0: return 12'h780;
            2'h1: return 12'h816;
            2'h2: return 12'h92e;
            default: return 12'ha46;
        endcase
    endfunction : amvg_gain_cdbv

    // Overcurrent trip level in percent of the limit
    function automatic logic [6:0] amvg_oc_percent(input logic [1:0] code);
        case (code)
            2'h0: return 7'h64;
            2'h1: return 7'h4b;
            2'h2: return 7'h32;
            default: return 7'h19;
        endcase
    endfunction : amvg_oc_percent

endpackage : amvg_pkg

// *** src/amvg_vol_ramp.sv ***
`timescale 1ns/10ps
// ****************************************************************
// Volume ramp: steps the applied code one quarter dB at a time
// ****************************************************************
module amvg_vol_ramp (
    // Clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // Frame timing and rate
    input  wire logic                          frame_tick_i,
    input  wire logic                          ramp_fast_i,
    // Target and applied code
    input  wire logic [amvg_pkg::AMVG_VOL_W-1:0] target_i,
    output logic      [amvg_pkg::AMVG_VOL_W-1:0] code_o,
    output logic                               moving_o
);
    import amvg_pkg::*;

    amvg_ramp_e            state_q, state_d;
    logic [2:0]            cnt_q,   cnt_d;
    logic [AMVG_VOL_W-1:0] cur_q,   cur_d;

    // Next state: one step per frame period when fast, else per eight
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        cur_d   = cur_q;
        case (state_q)
            AMVG_RAMP_IDLE: begin
                cnt_d = 3'h0;
                if (cur_q != target_i) begin
                    state_d = AMVG_RAMP_MOVE;
                end
            end
            default: begin
                if (cur_q == target_i) begin
                    state_d = AMVG_RAMP_IDLE;
                end else if (frame_tick_i) begin
                    if (ramp_fast_i || cnt_q == AMVG_RAMP_CNT_MAX) begin
                        cnt_d = 3'h0;
                        cur_d = (cur_q < target_i) ? cur_q + 9'h001 : cur_q - 9'h001;
                    end else begin
                        cnt_d = cnt_q + 3'h1;
                    end
                end
            end
        endcase
    end

    // Registers; starts at the zero dB code so reset needs no ramp
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= AMVG_RAMP_IDLE;
            cnt_q   <= 3'h0;
            cur_q   <= AMVG_VOL_ZERO_DB;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            cur_q   <= cur_d;
        end
    end

    assign code_o   = cur_q;
    assign moving_o = (state_q == AMVG_RAMP_MOVE);

endmodule : amvg_vol_ramp

// *** dv/amvg_regs_checker.sv ***
`timescale 1ns/10ps
// ****************************************************************
// Port checker for the register slice
// ****************************************************************
module amvg_regs_checker (
    // Clock and reset
    input wire logic                    clk_i,
    input wire logic                    rst_i,
    // Register port
    input wire amvg_pkg::amvg_reg_req_s reg_req_i,
    input wire logic [7:0]              reg_rdata_o,
    input wire logic                    reg_rvalid_o,
    // Controls and faults
    input wire logic                    speed_mode_sel_i,
    input wire amvg_pkg::amvg_fault_s   fault_i,
    // Observed outputs
    input wire logic [8:0]              digital_volume_o,
    input wire logic [9:0]              volume_qdb_o,
    input wire logic                    vol_muted_o,
    input wire logic [4:0]              pwm_ratio_o,
    input wire logic [1:0]              analog_gain_o,
    input wire logic [1:0]              overcurrent_threshold_o,
    input wire logic                    clock_error_flag_o,
    input wire logic                    overcurrent_flag_o,
    input wire logic                    dc_detect_flag_o,
    input wire logic                    overtemp_flag_o
);
    import amvg_pkg::*;

    // Own ratio table, kept apart from the design's decoder on purpose
    function automatic logic [4:0] ratio_f(input logic [2:0] c, input logic d);
        logic [4:0] r;
        r = (c < 3'h6) ? 5'h06 + {1'b0, c, 1'b0} : ((c == 3'h6) ? 5'h14 : 5'h18);
        return d ? (r >> 1) : r;
    endfunction : ratio_f

    // Request shapes
    sequence wr_analog_s;
        reg_req_i.wr && reg_req_i.addr == AMVG_OFS_ANALOG;
    endsequence
    sequence wr_fault_s;
        reg_req_i.wr && reg_req_i.addr == AMVG_OFS_FAULT;
    endsequence
    sequence rd_fault_s;
        reg_req_i.rd && reg_req_i.addr == AMVG_OFS_FAULT;
    endsequence

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Settings outputs sit one register stage behind the stored field, so writes check at ##2
    rvalid_pulse_a: assert property (1'b1 |=> reg_rvalid_o == $past(reg_req_i.rd))
        else $error("read valid does not follow the read strobe");
    rdata_idle_a: assert property (!reg_req_i.rd |=> reg_rdata_o == 8'h00)
        else $error("read data not zero without a read");
    pwm_write_a: assert property (wr_analog_s |-> ##2 pwm_ratio_o ==
        ratio_f($past(reg_req_i.wdata[6:4], 2), $past(speed_mode_sel_i)))
        else $error("switching ratio does not match the written code");
    gain_write_a: assert property (wr_analog_s |-> ##2
        analog_gain_o == $past(reg_req_i.wdata[3:2], 2))
        else $error("analog gain does not match the written code");
    thresh_write_a: assert property (wr_fault_s |-> ##2
        overcurrent_threshold_o == $past(reg_req_i.wdata[5:4], 2))
        else $error("threshold does not match the written code");
    fault_read_a: assert property (rd_fault_s |=>
        reg_rdata_o[3:0] == $past({clock_error_flag_o,
        overcurrent_flag_o, dc_detect_flag_o, overtemp_flag_o}))
        else $error("status read does not show the flags");
    clk_err_track_a: assert property (1'b1 |=>
        clock_error_flag_o == $past(fault_i.clk_err))
        else $error("clock error flag does not track its source");
    flag_set_a: assert property (1'b1 |=> ({overcurrent_flag_o, dc_detect_flag_o,
        overtemp_flag_o} & $past(fault_i[2:0])) == $past(fault_i[2:0]))
        else $error("fault event not flagged");
    oc_latch_a: assert property (overcurrent_flag_o && !reg_req_i.rd
        && !$past(reg_req_i.rd) && !$past(reg_req_i.rd, 2) |=> overcurrent_flag_o)
        else $error("overcurrent flag dropped without a read");
    ramp_step_a: assert property (digital_volume_o != $past(digital_volume_o) |->
        (digital_volume_o == $past(digital_volume_o) + 9'h001) ||
        (digital_volume_o == $past(digital_volume_o) - 9'h001))
        else $error("volume moved by more than one step");
    qdb_map_a: assert property (volume_qdb_o == {1'b0, digital_volume_o} - 10'h19e)
        else $error("quarter dB value off the linear map");
    mute_zero_a: assert property (vol_muted_o |-> digital_volume_o == 9'h000)
        else $error("muted with a nonzero volume code");
endmodule : amvg_regs_checker

bind amvg_regs amvg_regs_checker u_chk (
    .clk_i, .rst_i, .reg_req_i, .reg_rdata_o, .reg_rvalid_o, .speed_mode_sel_i, .fault_i,
    .digital_volume_o, .volume_qdb_o, .vol_muted_o, .pwm_ratio_o, .analog_gain_o,
    .overcurrent_threshold_o, .clock_error_flag_o, .overcurrent_flag_o, .dc_detect_flag_o,
    .overtemp_flag_o
);

// *** dv/amvg_host_model.sv ***
`timescale 1ns/10ps
// ****************************************************************
// Host controller on the register port
// ****************************************************************
module amvg_host_model (
    // Clock
    input  wire logic                   clk_i,
    // Register port
    output amvg_pkg::amvg_reg_req_s     reg_req_o,
    input  wire logic [7:0]             reg_rdata_i,
    input  wire logic                   reg_rvalid_i
);
    import amvg_pkg::*;

    // Idle port from time zero
    initial begin
        reg_req_o = '0;
    end

    // Write one byte; reserved analog bits always go out as required
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        logic [7:0] d;
        d = data;
        if (addr == AMVG_OFS_ANALOG) begin
            d[7]   = 1'b0;
            d[1:0] = 2'b01;
        end
        @(negedge clk_i);
        reg_req_o <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: d};
        @(negedge clk_i);
        reg_req_o <= '0;
    endtask : write_reg

    // Read one byte; answer is taken one cycle after the strobe
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
        @(negedge clk_i);
        reg_req_o <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(negedge clk_i);
        data = reg_rdata_i;
        ok   = reg_rvalid_i;
        reg_req_o <= '0;
    endtask : read_reg
endmodule : amvg_host_model

// *** dv/amvg_regs_bench.sv ***
`timescale 1ns/10ps
// ****************************************************************
// Self-checking bench for the register slice
// ****************************************************************
module amvg_regs_bench;
    import amvg_pkg::*;

    // Stimulus and observed signals
    logic          clk_i, rst_i, vol_lsb, mute, ramp_fast, speed, tick, tick_en;
    amvg_reg_req_s req;
    amvg_fault_s   fault;
    logic [7:0]    rdata, got;
    logic          rvalid, ok, muted, ramping, clock_error_flag, overcurrent_flag, dce, overtemp_flag;
    logic [8:0]    dvol;
    logic [9:0]    qdb;
    logic [4:0]    ratio;
    logic [1:0]    gain, thr;
    logic [11:0]   cdbv;
    logic [6:0]    pct;
    int            fails, checks;

    // Expected tables
    localparam logic [4:0]  RATIO [8] = '{5'h06, 5'h08, 5'h0a, 5'h0c, 5'h0e, 5'h10, 5'h14, 5'h18};
    localparam logic [11:0] CDBV  [4] = '{12'h780, 12'h816, 12'h92e, 12'ha46};
    localparam logic [6:0]  PCT   [4] = '{7'h64, 7'h4b, 7'h32, 7'h19};

    // Clock and a frame tick every other cycle while enabled
    initial clk_i = 1'b0;
    always #25 clk_i = ~clk_i;
    always @(negedge clk_i) tick <= tick_en & ~tick;

    amvg_regs uut (
        .clk_i(clk_i), .rst_i(rst_i), .reg_req_i(req), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .vol_lsb_i(vol_lsb), .mute_i(mute),
        .ramp_rate_sel_i(ramp_fast), .speed_mode_sel_i(speed), .frame_tick_i(tick),
        .fault_i(fault), .digital_volume_o(dvol), .volume_qdb_o(qdb), .vol_muted_o(muted),
        .vol_ramping_o(ramping), .pwm_ratio_o(ratio), .analog_gain_o(gain),
        .analog_gain_cdbv_o(cdbv), .overcurrent_threshold_o(thr), .oc_percent_o(pct),
        .clock_error_flag_o(clock_error_flag), .overcurrent_flag_o(overcurrent_flag), .dc_detect_flag_o(dce),
        .overtemp_flag_o(overtemp_flag)
    );
    amvg_host_model host (
        .clk_i(clk_i), .reg_req_o(req), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid)
    );

    task automatic wrap_up;
        if (fails == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [11:0] got_v, input logic [11:0] exp_v);
        checks++;
        if (got_v !== exp_v) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got_v, exp_v);
        end
    endtask : chk

    // Read and compare data with the valid pulse folded in
    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp_v);
        host.read_reg(addr, got, ok);
        chk({3'h0, ok, got}, {4'h1, exp_v});
    endtask : rd_chk

    // Bounded wait for the ramp to land; running out ends the run
    task automatic wait_vol(input logic [8:0] target);
        int n;
        n = 0;
        while (dvol !== target && n < 2000) begin
            @(negedge clk_i);
            n++;
        end
        chk({3'h0, dvol}, {3'h0, target});
        if (dvol !== target) wrap_up();
    endtask : wait_vol

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset;
        chk({3'h0, dvol}, 12'h19e);
        chk({7'h0, ratio}, 12'h010);
        chk({10'h0, gain}, 12'h001);
        rd_chk(AMVG_OFS_VOLUME, 8'hcf);
        rd_chk(AMVG_OFS_ANALOG, 8'h55);
        rd_chk(AMVG_OFS_FAULT, 8'h00);
        rd_chk(8'h05, 8'h00);
    endtask : t_reset

    task automatic t_analog;
        for (int s = 0; s < 2; s++) begin
            speed = s[0];
            for (int c = 0; c < 8; c++) begin
                host.write_reg(AMVG_OFS_ANALOG, {1'b1, c[2:0], c[1:0], 2'b10});
                @(negedge clk_i); // Outputs follow the stored field one edge later
                chk({7'h0, ratio}, {7'h0, s[0] ? RATIO[c] >> 1 : RATIO[c]});
                chk(cdbv, CDBV[c[1:0]]);
                rd_chk(AMVG_OFS_ANALOG, {1'b0, c[2:0], c[1:0], 2'b01});
            end
        end
        speed = 1'b0;
    endtask : t_analog

    task automatic t_fault;
        for (int c = 0; c < 4; c++) begin
            host.write_reg(AMVG_OFS_FAULT, {2'h0, c[1:0], 4'hf});
            @(negedge clk_i);
            chk({5'h0, pct}, {5'h0, PCT[c]});
            chk({10'h0, thr}, {10'h0, c[1:0]});
            rd_chk(AMVG_OFS_FAULT, {2'h0, c[1:0], 4'h0});
        end
        // One-cycle events must stick; the clock error follows its level
        fault = 4'hf;
        @(negedge clk_i);
        fault = 4'h8;
        repeat (4) @(negedge clk_i);
        chk({8'h0, clock_error_flag, overcurrent_flag, dce, overtemp_flag}, 12'h00f);
        fault = 4'h0;
        repeat (2) @(negedge clk_i);
        chk({8'h0, clock_error_flag, overcurrent_flag, dce, overtemp_flag}, 12'h007);
        rd_chk(AMVG_OFS_FAULT, 8'h37);
        repeat (2) @(negedge clk_i);
        rd_chk(AMVG_OFS_FAULT, 8'h30);
    endtask : t_fault

    task automatic t_volume;
        ramp_fast = 1'b1;
        tick_en = 1'b1;
        host.write_reg(AMVG_OFS_VOLUME, 8'h03);
        wait_vol(9'h000);
        host.write_reg(AMVG_OFS_VOLUME, 8'h04);
        wait_vol(9'h008);
        host.write_reg(AMVG_OFS_VOLUME, 8'hd0);
        vol_lsb = 1'b1;
        wait_vol(9'h1a1);
        chk({2'h0, qdb}, 12'h003);
        // Slow rate: 32 ticks may give at most four steps
        ramp_fast = 1'b0;
        mute = 1'b1;
        repeat (64) @(negedge clk_i);
        chk({11'h0, dvol inside {[9'h19c:9'h19e]}}, 12'h001);
        chk({11'h0, ramping}, 12'h001);
        ramp_fast = 1'b1;
        wait_vol(9'h000);
        chk({11'h0, muted}, 12'h001);
        mute = 1'b0;
        wait_vol(9'h1a1);
        tick_en = 1'b0;
        vol_lsb = 1'b0;
    endtask : t_volume

    // Main sequence, with a second reset in mid-run
    initial begin
        rst_i = 1'b1;
        {vol_lsb, mute, ramp_fast, speed, tick_en} = 5'h00;
        fault = '0;
        fails = 0;
        checks = 0;
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        t_reset();
        t_analog();
        t_fault();
        t_volume();
        rst_i = 1'b1;
        @(negedge clk_i);
        rst_i = 1'b0;
        t_reset();
        wrap_up();
    end
endmodule : amvg_regs_bench
